/* File: common/sjsb_pkg.sv */
// shared constants for the short jump / subtract-with-borrow execution block
package sjsb_pkg;
  localparam int SJSB_PC_W = 16;
  localparam int SJSB_BYTE_W = 8;
  localparam logic [7:0] SJSB_OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] SJSB_OP_SUB_DIRECT = 8'h95;
  localparam logic [7:0] SJSB_OP_SUB_IMM = 8'h94;
  localparam logic [6:0] SJSB_OP_SUB_IND_HI = 7'h4B;
  localparam logic [4:0] SJSB_OP_SUB_REG_HI = 5'h13;
  localparam logic [15:0] SJSB_JUMP_LEN = 16'h0002;
  localparam logic [15:0] SJSB_PC_RST = 16'h0000;
  localparam logic [7:0] SJSB_ACC_RST = 8'h00;
  localparam int SJSB_NIB_MSB = 3;
  localparam int SJSB_SIGN_BIT = 7;
  localparam int SJSB_JUMP_CYCLES = 2;
  localparam int SJSB_SUB_CYCLES = 1;
  typedef enum logic [2:0] {
    SJSB_SRC_NONE,
    SJSB_SRC_REG,
    SJSB_SRC_DIRECT,
    SJSB_SRC_INDIRECT,
    SJSB_SRC_IMM
  } sjsb_src_e;
endpackage

/* File: rtl/sjsb_exec.sv */
// execution of the short relative jump and subtract-with-borrow
module sjsb_exec
#(
  parameter int PC_W = sjsb_pkg::SJSB_PC_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // decoded instruction from fetch, one pulse per instruction
  input wire logic i_valid,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_operand,
  // operand fetched by the core for non-immediate sources
  input wire logic [7:0] i_src_data,
  // pc and carry flag loaded by other instructions
  input wire logic i_pc_load,
  input wire logic [PC_W-1:0] i_pc_value,
  input wire logic i_carry_load,
  input wire logic i_carry_value,
  // architectural state
  output logic [PC_W-1:0] o_pc,
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_aux_carry,
  output logic o_overflow,
  // source selection and status
  output logic [2:0] o_src_mode,
  output logic [2:0] o_src_reg,
  output logic o_busy,
  output logic o_done
);
  import sjsb_pkg::*;

  typedef enum logic {SJSB_IDLE, SJSB_JUMP_WAIT} sjsb_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // a narrower pc leaves no room to sign-extend the displacement
  if (PC_W < 9 || PC_W > 32) begin
    $error("sjsb_exec pc width must be 9..32");
  end

  function automatic sjsb_src_e sjsb_src_of(input logic [7:0] op);
    if (op == SJSB_OP_SUB_DIRECT) sjsb_src_of = SJSB_SRC_DIRECT;
    else if (op == SJSB_OP_SUB_IMM) sjsb_src_of = SJSB_SRC_IMM;
    else if (op[7:1] == SJSB_OP_SUB_IND_HI) sjsb_src_of = SJSB_SRC_INDIRECT;
    else if (op[7:3] == SJSB_OP_SUB_REG_HI) sjsb_src_of = SJSB_SRC_REG;
    else sjsb_src_of = SJSB_SRC_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sjsb_src_e src;
  logic is_jump;
  logic [7:0] operand;
  logic [7:0] diff;
  logic borrow;
  logic aux_borrow;
  logic ovf;

  always_comb begin
    src = i_valid ? sjsb_src_of(i_opcode) : SJSB_SRC_NONE;
    is_jump = i_valid && (i_opcode == SJSB_OP_SHORT_JUMP);
    // immediate comes with the instruction, other modes from the core
    operand = (src == SJSB_SRC_IMM) ? i_operand : i_src_data;
  end

  sjsb_sub_alu #(
    .WIDTH(SJSB_BYTE_W)
  ) u_alu (
    .i_acc(o_acc),
    .i_src(operand),
    .i_carry(o_carry),
    .o_diff(diff),
    .o_borrow(borrow),
    .o_aux_borrow(aux_borrow),
    .o_overflow(ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  sjsb_state_e state;
  sjsb_state_e next_state;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] next_target;
  logic done;
  logic next_done;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic cy;
  logic next_cy;
  logic ac;
  logic next_ac;
  logic ov;
  logic next_ov;
  logic idle;
  logic take_jump;
  logic take_sub;
  logic [PC_W-1:0] pc_step;
  logic [PC_W-1:0] disp_ext;

  // a pc load in idle drops whatever instruction shares its cycle
  always_comb begin
    idle = (state == SJSB_IDLE);
    take_jump = idle && !i_pc_load && is_jump;
    take_sub = idle && !i_pc_load && (src != SJSB_SRC_NONE);
    pc_step = PC_W'(SJSB_JUMP_LEN);
    // sign-extend so a negative byte walks back up to 128 bytes
    disp_ext = {{(PC_W-SJSB_BYTE_W){i_operand[SJSB_SIGN_BIT]}}, i_operand};
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: a jump needs a second machine cycle to commit
  always_comb begin
    next_state = state;
    next_target = target;
    next_done = 1'b0;
    unique case (state)
      SJSB_IDLE: begin
        if (take_jump) begin
          // advance past both bytes first, then add; wraps modulo pc width
          next_target = pc + pc_step + disp_ext;
          next_state = SJSB_JUMP_WAIT;
        end else if (take_sub) begin
          next_done = 1'b1;
        end
      end
      SJSB_JUMP_WAIT: begin
        next_done = 1'b1;
        next_state = SJSB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= SJSB_IDLE;
      target <= PC_W'(SJSB_PC_RST);
      done <= 1'b0;
    end else begin
      state <= next_state;
      target <= next_target;
      done <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter: loads only land in idle so a jump cannot be torn
  always_comb begin
    next_pc = pc;
    if (!idle) begin
      // second machine cycle commits the branch; flags untouched
      next_pc = target;
    end else if (i_pc_load) begin
      next_pc = i_pc_value;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc <= PC_W'(SJSB_PC_RST);
    end else begin
      pc <= next_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and flags; the jump path never reaches them
  always_comb begin
    next_acc = acc;
    next_cy = cy;
    next_ac = ac;
    next_ov = ov;
    if (i_carry_load) begin
      next_cy = i_carry_value;
    end
    // a subtract in the same cycle beats a carry written from outside
    if (take_sub) begin
      next_acc = diff;
      next_cy = borrow;
      next_ac = aux_borrow;
      next_ov = ovf;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc <= SJSB_ACC_RST;
      cy <= 1'b0;
      ac <= 1'b0;
      ov <= 1'b0;
    end else begin
      acc <= next_acc;
      cy <= next_cy;
      ac <= next_ac;
      ov <= next_ov;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection follows the offered opcode, even while busy;
  // the core ignores it unless the subtract is actually taken
  always_comb begin
    o_pc = pc;
    o_acc = acc;
    o_carry = cy;
    o_aux_carry = ac;
    o_overflow = ov;
    o_src_mode = src;
    // register number in the low bits; indirect uses bit 0 only
    o_src_reg = i_opcode[2:0];
    o_busy = (state == SJSB_JUMP_WAIT);
    o_done = done;
  end
endmodule

/* File: rtl/sjsb_sub_alu.sv */
// subtract-with-borrow arithmetic with flag generation
module sjsb_sub_alu
#(
  parameter int WIDTH = 8
) (
  // operands
  input wire logic [WIDTH-1:0] i_acc,
  input wire logic [WIDTH-1:0] i_src,
  input wire logic i_carry,
  // result and flags
  output logic [WIDTH-1:0] o_diff,
  output logic o_borrow,
  output logic o_aux_borrow,
  output logic o_overflow
);
  import sjsb_pkg::*;
  logic [WIDTH:0] full;
  logic [4:0] nib;
  logic [WIDTH-1:0] low;
  if (WIDTH != 8) begin
    $error("sjsb_sub_alu serves only 8-bit data");
  end
  always_comb begin
    full = {1'b0, i_acc} - {1'b0, i_src} - {{WIDTH{1'b0}}, i_carry};
    nib = {1'b0, i_acc[3:0]} - {1'b0, i_src[3:0]} - {4'h0, i_carry};
    // borrow into bit 7 comes out of the low seven bits
    low = {1'b0, i_acc[WIDTH-2:0]} - {1'b0, i_src[WIDTH-2:0]}
      - {{(WIDTH-1){1'b0}}, i_carry};
    o_diff = full[WIDTH-1:0];
    o_borrow = full[WIDTH];
    o_aux_borrow = nib[4];
    o_overflow = full[WIDTH] ^ low[WIDTH-1];
  end
endmodule

/* File: test/short_jump_and_subtract_borrow_tb.sv */
// self-checking bench for the jump / subtract block
module short_jump_and_subtract_borrow_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sjsb_pkg::*;
  logic i_clk = 0, i_rst_b = 0, i_valid = 0, i_pc_load = 0, i_carry_load = 0;
  logic i_carry_value = 0, o_carry, o_aux_carry, o_overflow, o_busy, o_done;
  logic [7:0] i_opcode = 0, i_operand = 0, i_src_data = 0, o_acc;
  logic [15:0] i_pc_value = 0, o_pc;
  logic [2:0] o_src_mode, o_src_reg, mode_seen, reg_seen;
  int err_count = 0, tests_run = 0;
  // opcode, source, result, carry/aux/overflow, source mode; carry chains row to row
  logic [29:0] rows [7] = '{{8'h94, 8'h37, 8'hC9, 3'h6, 3'h4}, {8'h9A, 8'h54, 8'h74, 3'h1, 3'h1},
    {8'h95, 8'h80, 8'hF4, 3'h5, 3'h2}, {8'h96, 8'h7F, 8'h74, 3'h3, 3'h3},
    {8'h97, 8'h74, 8'h00, 3'h0, 3'h3}, {8'h9F, 8'hFF, 8'h01, 3'h6, 3'h1},
    {8'h98, 8'h00, 8'h00, 3'h0, 3'h1}};
  sjsb_exec dut_u (.*);
  always #4 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [7:0] op, input logic [7:0] opnd, input logic [7:0] src);
    @(posedge i_clk);
    i_valid <= 1;
    i_opcode <= op;
    i_operand <= opnd;
    i_src_data <= src;
    // source selection only stands while the instruction is offered
    @(negedge i_clk);
    mode_seen = o_src_mode;
    reg_seen = o_src_reg;
    @(posedge i_clk);
    i_valid <= 0;
    @(negedge i_clk);
  endtask
  // the unused source byte is inverted to catch a wrong source pick
  task automatic sub(input logic [29:0] r);
    logic imm;
    imm = (r[29:22] == 8'h94);
    issue(r[29:22], imm ? r[21:14] : ~r[21:14], imm ? ~r[21:14] : r[21:14]);
    chk(o_acc, r[13:6]);
    chk({o_carry, o_aux_carry, o_overflow, o_done}, {r[5:3], 1'b1});
    chk(mode_seen, r[2:0]);
    chk(reg_seen, r[24:22]);
  endtask
  task automatic load(input logic [15:0] v);
    @(posedge i_clk);
    i_pc_load <= 1;
    i_pc_value <= v;
    @(posedge i_clk);
    i_pc_load <= 0;
  endtask
  task automatic jump(input logic [7:0] d, input logic [15:0] e);
    issue(8'h80, d, 8'h00);
    chk(mode_seen, 3'h0);
    chk(o_busy, 1'b1);
    @(negedge i_clk);
    chk(o_pc, e);
    chk({o_done, o_busy, o_carry, o_aux_carry, o_overflow}, 5'h16);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1;
    @(negedge i_clk);
    chk({o_pc, o_acc}, 24'h0);
    foreach (rows[k]) begin
      sub(rows[k]);
    end
    @(posedge i_clk);
    i_carry_load <= 1;
    i_carry_value <= 1;
    @(posedge i_clk);
    i_carry_load <= 0;
    sub({8'h94, 8'h10, 8'hEF, 3'h6, 3'h4});
    load(16'h0100);
    jump(8'h21, 16'h0123);
    jump(8'h80, 16'h00A5);
    jump(8'h7F, 16'h0126);
    jump(8'hFE, 16'h0126);
    load(16'hFFFF);
    jump(8'h05, 16'h0006);
    // a subtract offered while the jump is busy must be dropped
    @(posedge i_clk);
    i_valid <= 1;
    i_opcode <= 8'h80;
    i_operand <= 8'h00;
    @(posedge i_clk);
    i_opcode <= 8'h94;
    @(posedge i_clk);
    i_valid <= 0;
    @(negedge i_clk);
    chk({o_pc, o_acc}, {16'h0008, 8'hEF});
    give_verdict();
  end
  initial begin
    #5000;
    err_count++;
    give_verdict();
  end
endmodule

/* File: test/sjsb_exec_monitor.sv */
// assertions for the jump / subtract block
module sjsb_exec_monitor
  import sjsb_pkg::*;
#(parameter int PC_W = 16) (
  input wire logic i_clk, i_rst_b, i_valid, i_pc_load, o_carry, o_aux_carry, o_overflow,
  input wire logic o_busy, o_done,
  input wire logic [7:0] i_opcode, i_operand, i_src_data, o_acc,
  input wire logic [2:0] o_src_mode, o_src_reg,
  input wire logic [PC_W-1:0] o_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // immediate form carries its source in the second byte
  wire logic [7:0] s = (i_opcode == 8'h94) ? i_operand : i_src_data;
  wire logic [8:0] d = {1'b0, o_acc} - {1'b0, s} - 9'(o_carry);
  wire logic [4:0] n = {1'b0, o_acc[3:0]} - {1'b0, s[3:0]} - 5'(o_carry);
  wire logic [7:0] l = {1'b0, o_acc[6:0]} - {1'b0, s[6:0]} - 8'(o_carry);
  wire logic [PC_W-1:0] t = o_pc + PC_W'(2'h2) + PC_W'(signed'(i_operand));
  // a pc load in idle drops the instruction
  wire logic go = i_valid && !o_busy && !i_pc_load;
  sequence s_sub;
    go && i_opcode[7:4] == 4'h9 && i_opcode[3:2] != 2'h0;
  endsequence
  sequence s_jmp;
    go && i_opcode == 8'h80;
  endsequence
  a_sub_acc: assert property (s_sub |=> o_acc == $past(d[7:0]) && o_done)
    else $error("subtract result wrong");
  a_sub_carry: assert property (s_sub |=> o_carry == $past(d[8]))
    else $error("subtract carry wrong");
  a_sub_aux: assert property (s_sub |=> o_aux_carry == $past(n[4]))
    else $error("subtract aux carry wrong");
  a_sub_ovf: assert property (s_sub |=> o_overflow == $past(l[7] ^ d[8]))
    else $error("subtract overflow wrong");
  a_direct_mode: assert property (i_valid && i_opcode == 8'h95 |-> o_src_mode == 3'h2)
    else $error("direct source mode wrong");
  a_reg_number: assert property (i_valid && i_opcode[7:3] == 5'h13 |-> o_src_reg == i_opcode[2:0])
    else $error("work register number wrong");
  a_jump_timing: assert property (s_jmp |=> o_busy ##1 (o_done && !o_busy))
    else $error("jump timing wrong");
  a_jump_target: assert property (s_jmp |=> ##1 o_pc == $past(t, 2))
    else $error("jump target wrong");
  a_jump_flags: assert property (s_jmp |=> ##1
    $past({o_acc, o_aux_carry, o_overflow}, 2) == {o_acc, o_aux_carry, o_overflow})
    else $error("jump touched a flag");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sjsb_exec sjsb_exec_monitor #(.PC_W(PC_W)) mon_u (.*);
